//--- verilog/asc_defs.vh
// Constants for the advanced sequence control block
`ifndef ASC_DEFS_VH
`define ASC_DEFS_VH
`define ASC_OFF_CTRL     12'h000
`define ASC_OFF_LENGTH   12'h004
`define ASC_OFF_ONCE     12'h008
`define ASC_OFF_SYNC     12'h00c
`define ASC_OFF_STATUS   12'h010
`define ASC_OFF_TADDR    12'h014
`define ASC_OFF_TLO      12'h018
`define ASC_OFF_THI      12'h01c
`define ASC_OFF_BLKLD    12'h020
`define ASC_LEN_RST      10'h001
`define ASC_ONCE_RST     20'h00001
`define ASC_SYNC_RST     10'h001
`define ASC_LEN_MAX      10'h3e8
`define ASC_CTRL_RUN     0
`define ASC_CTRL_MODE_LO 1
`define ASC_CTRL_MODE_HI 2
`define ASC_MODE_AUTO    2'h0
`define ASC_MODE_ONCE    2'h1
`define ASC_MODE_STEP    2'h2
`define ASC_HI_JUMP      30
`define ASC_SEQ_LO       20
`define ASC_SEQ_HI       29
`endif

//--- verilog/asc_event_sync.v
// Event input synchroniser and edge detector
`timescale 1ns/1ns
module asc_event_sync (
	input  wire hclk,     // Clock
	input  wire hresetn,  // Async reset, active low
	input  wire event_in, // External event level
	output reg  event_req // One pulse per rising edge
);
	reg s1_reg;
	reg s2_reg;
	reg s3_reg;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_reg    <= 1'b0;
			s2_reg    <= 1'b0;
			s3_reg    <= 1'b0;
			event_req <= 1'b0;
		end else begin
			s1_reg    <= event_in;
			s2_reg    <= s1_reg;
			s3_reg    <= s2_reg;
			event_req <= s2_reg & ~s3_reg;
		end
	end
endmodule

//--- verilog/asc_top.v
// Advanced sequence control with AHB-Lite register slave
`timescale 1ns/1ns
`include "asc_defs.vh"
module asc_top #(
	parameter DEPTH = 1000,         // Table steps
	parameter SEQ_CYCLES = 16'h0004 // Clock cycles per sequence play
) (
	input  wire        hclk,      // Clock, 20 MHz
	input  wire        hresetn,   // Async reset, active low
	input  wire        hsel,      // Slave select
	input  wire [31:0] haddr,     // Address
	input  wire [1:0]  htrans,    // Transfer type
	input  wire        hwrite,    // Write
	input  wire [2:0]  hsize,     // Size
	input  wire [31:0] hwdata,    // Write data
	input  wire        hready,    // Bus ready
	output reg  [31:0] hrdata,    // Read data
	output reg         hreadyout, // Slave ready
	output reg         hresp,     // Response, always OKAY
	input  wire        event_in,  // External event
	output reg         sync_out,  // Sync pulse
	output reg  [9:0]  seq_num,   // Sequence being played
	output reg         running    // Sequencer active
);
	localparam ST_IDLE = 3'b001;
	localparam ST_PLAY = 3'b010;
	localparam ST_HOLD = 3'b100;

	reg [19:0] tbl_lo [0:DEPTH-1];
	reg [9:0]  tbl_seq [0:DEPTH-1];
	reg        tbl_jmp [0:DEPTH-1];
	reg [9:0]  len_reg;
	reg [19:0] once_reg;
	reg [9:0]  sync_reg;
	reg [2:0]  ctrl_reg;
	reg [9:0]  taddr_reg;
	reg [9:0]  blk_reg;
	reg        blk_on_reg;
	reg        wr_pend;
	reg [11:0] wa_reg;
	reg [2:0]  state_reg;
	reg [9:0]  step_reg;
	reg [19:0] loop_reg;
	reg [19:0] pass_reg;
	reg [15:0] cyc_reg;
	reg        run_d;
	wire       event_req;

	function [9:0] clip_len;
		input [31:0] v;
		begin
			if (v[31:0] == 32'h0)
				clip_len = `ASC_LEN_RST;
			else if (v > {22'h0, `ASC_LEN_MAX})
				clip_len = `ASC_LEN_MAX;
			else
				clip_len = v[9:0];
		end
	endfunction

	asc_event_sync u_sync (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.event_in  (event_in),
		.event_req (event_req)
	);

	wire       take = hsel & hready & htrans[1];
	wire [1:0] mode = ctrl_reg[`ASC_CTRL_MODE_HI:`ASC_CTRL_MODE_LO];
	wire       run  = ctrl_reg[`ASC_CTRL_RUN];
	wire [19:0] step_loops = tbl_lo[step_reg];
	wire       last_step = (step_reg == len_reg - 10'h001);
	wire       play_done = (cyc_reg == SEQ_CYCLES - 16'h0001);

	// Table storage; block load counts steps as they arrive
	always @(posedge hclk) begin
		if (wr_pend && wa_reg == `ASC_OFF_TLO)
			tbl_lo[taddr_reg] <= hwdata[19:0];
		if (wr_pend && wa_reg == `ASC_OFF_THI) begin
			tbl_seq[taddr_reg] <= hwdata[`ASC_SEQ_HI:`ASC_SEQ_LO];
			tbl_jmp[taddr_reg] <= hwdata[`ASC_HI_JUMP];
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata     <= 32'h0;
			hreadyout  <= 1'b1;
			hresp      <= 1'b0;
			wr_pend    <= 1'b0;
			wa_reg     <= 12'h0;
			len_reg    <= `ASC_LEN_RST;
			once_reg   <= `ASC_ONCE_RST;
			sync_reg   <= `ASC_SYNC_RST;
			ctrl_reg   <= 3'h0;
			taddr_reg  <= 10'h0;
			blk_reg    <= 10'h0;
			blk_on_reg <= 1'b0;
		end else begin
			wr_pend <= take & hwrite;
			if (take)
				wa_reg <= haddr[11:0];
			if (take && !hwrite) begin
				case (haddr[11:0])
				`ASC_OFF_CTRL:   hrdata <= {29'h0, ctrl_reg};
				`ASC_OFF_LENGTH: hrdata <= {22'h0, len_reg};
				`ASC_OFF_ONCE:   hrdata <= {12'h0, once_reg};
				`ASC_OFF_SYNC:   hrdata <= {22'h0, sync_reg};
				`ASC_OFF_STATUS: hrdata <= {19'h0, step_reg, state_reg};
				`ASC_OFF_TADDR:  hrdata <= {22'h0, taddr_reg};
				default:         hrdata <= 32'h0;
				endcase
			end
			if (wr_pend) begin
				case (wa_reg)
				`ASC_OFF_CTRL:   ctrl_reg <= hwdata[2:0];
				`ASC_OFF_LENGTH: len_reg <= clip_len(hwdata);
				`ASC_OFF_ONCE:
					once_reg <= (hwdata[19:0] == 20'h0) ? `ASC_ONCE_RST : hwdata[19:0];
				`ASC_OFF_SYNC:   sync_reg <= clip_len(hwdata);
				`ASC_OFF_TADDR:  taddr_reg <= hwdata[9:0];
				`ASC_OFF_BLKLD: begin
					blk_on_reg <= hwdata[0];
					if (hwdata[0]) begin
						blk_reg   <= 10'h0;
						taddr_reg <= 10'h0;
					end else if (blk_on_reg)
						len_reg <= clip_len({22'h0, blk_reg});
				end
				`ASC_OFF_THI: begin
					taddr_reg <= taddr_reg + 10'h001;
					if (blk_on_reg)
						blk_reg <= blk_reg + 10'h001;
				end
				default: ;
				endcase
			end
		end
	end

	// Sequencer
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= ST_IDLE;
			step_reg  <= 10'h0;
			loop_reg  <= 20'h0;
			pass_reg  <= 20'h0;
			cyc_reg   <= 16'h0;
			run_d     <= 1'b0;
			sync_out  <= 1'b0;
			seq_num   <= 10'h0;
			running   <= 1'b0;
		end else begin
			run_d <= run;
			if (!run) begin
				state_reg <= ST_IDLE;
			end else begin
				case (state_reg)
				ST_IDLE: begin
					if (!run_d) begin
						state_reg <= ST_PLAY;
						step_reg  <= 10'h0;
						loop_reg  <= 20'h0;
						pass_reg  <= 20'h0;
						cyc_reg   <= 16'h0;
					end
				end
				ST_PLAY: begin
					cyc_reg <= play_done ? 16'h0 : cyc_reg + 16'h0001;
					if (play_done) begin
						if (loop_reg + 20'h00001 < step_loops) begin
							loop_reg <= loop_reg + 20'h00001;
						end else if (mode == `ASC_MODE_STEP || tbl_jmp[step_reg]) begin
							state_reg <= ST_HOLD;
						end else begin
							loop_reg <= 20'h0;
							if (last_step) begin
								step_reg <= 10'h0;
								if (mode == `ASC_MODE_ONCE) begin
									pass_reg <= pass_reg + 20'h00001;
									if (pass_reg + 20'h00001 >= once_reg)
										state_reg <= ST_IDLE;
								end
							end else
								step_reg <= step_reg + 10'h001;
						end
					end
				end
				ST_HOLD: begin
					// Dwell replays the step until the event arrives
					cyc_reg <= play_done ? 16'h0 : cyc_reg + 16'h0001;
					if (event_req) begin
						state_reg <= ST_PLAY;
						loop_reg  <= 20'h0;
						cyc_reg   <= 16'h0;
						step_reg  <= last_step ? 10'h0 : step_reg + 10'h001;
					end
				end
				default: state_reg <= ST_IDLE;
				endcase
			end
			running  <= (state_reg != ST_IDLE);
			// Held while idle: table entries not yet written would show unknowns
			if (state_reg != ST_IDLE)
				seq_num <= tbl_seq[step_reg];
			sync_out <= (state_reg != ST_IDLE) && (step_reg + 10'h001 == sync_reg);
		end
	end
endmodule

//--- sim/asc_ahb_host.sv
// Bus master model standing in for the host
`timescale 1ns/1ns
module asc_ahb_host (
	input  wire        hclk,   // Clock
	input  wire        hready, // Bus ready
	input  wire [31:0] hrdata, // Read data
	output reg         hsel,   // Select
	output reg  [31:0] haddr,  // Address
	output reg  [1:0]  htrans, // Transfer type
	output reg         hwrite, // Write
	output reg  [2:0]  hsize,  // Size
	output reg  [31:0] hwdata  // Write data
);
	initial begin
		{hsel, haddr, htrans, hwrite, hsize, hwdata} = 71'h0;
	end
	task xfer(input w, input [31:0] a, input [31:0] d, output [31:0] q);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		haddr <= ~a;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		q = hrdata;
		// Stale data must not look valid after the data phase
		hwdata <= ~d;
	endtask
endmodule

//--- sim/asc_assertions.sv
// Checker for the sequencer bus and sync outputs
`timescale 1ns/1ns
module asc_assertions (
	input wire        hclk,      // Clock
	input wire        hresetn,   // Reset, active low
	input wire        hsel,      // Select
	input wire        hwrite,    // Write
	input wire        hready,    // Bus ready
	input wire        event_in,  // External event
	input wire [31:0] haddr,     // Address
	input wire [31:0] hwdata,    // Write data
	input wire [31:0] hrdata,    // Read data
	input wire [1:0]  htrans,    // Transfer type
	input wire [2:0]  hsize,     // Size
	input wire        hreadyout, // Slave ready
	input wire        hresp,     // Response
	input wire        sync_out,  // Sync pulse
	input wire        running,   // Sequencer active
	input wire [9:0]  seq_num    // Sequence
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("hresp not okay");
	a_zero_wait: assert property (hreadyout)
		else $error("wait state inserted");
	a_sync_in_run: assert property (sync_out |-> running)
		else $error("sync while idle");
	a_sync_width: assert property ($rose(sync_out) |-> sync_out[*4])
		else $error("sync shorter than a play");
	a_step_dwell: assert property ($changed(seq_num) |=> $stable(seq_num)[*3])
		else $error("step shorter than a play");
	a_rdata_holds: assert property ($changed(hrdata) |-> $past(hsel && htrans[1] && !hwrite))
		else $error("read data moved without a read");
	a_idle_end: assert property ($fell(running) |-> !sync_out)
		else $error("sync left high at idle");
	a_reset_quiet: assert property ($rose(hresetn) |-> hreadyout && !running && !sync_out)
		else $error("outputs busy after reset");
	c_sync: cover property ($rose(sync_out));
	c_idle: cover property ($fell(running));
	c_step: cover property ($changed(seq_num));
endmodule
bind asc_top asc_assertions u_chk (
	.hclk      (hclk),
	.hresetn   (hresetn),
	.hsel      (hsel),
	.hwrite    (hwrite),
	.hready    (hready),
	.event_in  (event_in),
	.haddr     (haddr),
	.hwdata    (hwdata),
	.hrdata    (hrdata),
	.htrans    (htrans),
	.hsize     (hsize),
	.hreadyout (hreadyout),
	.hresp     (hresp),
	.sync_out  (sync_out),
	.running   (running),
	.seq_num   (seq_num)
);

//--- sim/tb_asc_top.sv
// Testbench for the advanced sequence control block
`timescale 1ns/1ns
`include "asc_defs.vh"
module tb_asc_top;
	reg         hclk, hresetn, event_in;
	wire        hsel, hwrite, hreadyout, hresp, sync_out, running;
	wire [31:0] haddr, hwdata, hrdata;
	wire [1:0]  htrans;
	wire [2:0]  hsize;
	wire [9:0]  seq_num;
	reg  [31:0] q;
	integer     err_total, check_count, cyc, n, i;
	asc_top dut (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hreadyout),
		.hrdata    (hrdata),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.event_in  (event_in),
		.sync_out  (sync_out),
		.seq_num   (seq_num),
		.running   (running)
	);
	asc_ahb_host host (
		.hclk   (hclk),
		.hready (hreadyout),
		.hrdata (hrdata),
		.hsel   (hsel),
		.haddr  (haddr),
		.htrans (htrans),
		.hwrite (hwrite),
		.hsize  (hsize),
		.hwdata (hwdata)
	);
	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end
	task cmp(input string nm, input [31:0] e, input [31:0] s);
		check_count = check_count + 1;
		if (s !== e) begin
			err_total = err_total + 1;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task wr(input [11:0] a, input [31:0] d);
		host.xfer(1'b1, {20'h0, a}, d, q);
	endtask
	task rdc(input [11:0] a, input [31:0] e);
		host.xfer(1'b0, {20'h0, a}, 32'h0, q);
		cmp("register", e, q);
	endtask
	task t_regs;
		rdc(`ASC_OFF_LENGTH, 32'h1);
		rdc(`ASC_OFF_ONCE, 32'h1);
		rdc(`ASC_OFF_SYNC, 32'h1);
		wr(`ASC_OFF_LENGTH, 32'h3e9);
		rdc(`ASC_OFF_LENGTH, 32'h3e8);
		wr(`ASC_OFF_ONCE, 32'hfffff);
		rdc(`ASC_OFF_ONCE, 32'hfffff);
		wr(`ASC_OFF_SYNC, 32'h0);
		rdc(`ASC_OFF_SYNC, 32'h1);
		rdc(12'h040, 32'h0);
	endtask
	task t_block;
		wr(`ASC_OFF_BLKLD, 32'h1);
		for (i = 0; i < 3; i = i + 1) begin
			wr(`ASC_OFF_TLO, 3 - i);
			wr(`ASC_OFF_THI, (i + 5) << 20);
		end
		wr(`ASC_OFF_BLKLD, 32'h0);
		rdc(`ASC_OFF_LENGTH, 32'h3);
	endtask
	task t_once;
		wr(`ASC_OFF_ONCE, 32'h2);
		wr(`ASC_OFF_CTRL, 32'h3);
		n = 0;
		// Sampled between edges, where the registered outputs have settled
		for (i = 0; i < 300 && (i < 3 || running); i = i + 1) begin
			@(negedge hclk);
			if (sync_out === 1'b1) n = n + 1;
		end
		// Step one loops three times of four cycles, twelve cycles in each of two passes
		cmp("sync cycles", 24, n);
		cmp("running", 0, running);
		@(posedge hclk);
		rdc(`ASC_OFF_STATUS, 32'h1);
	endtask
	task t_step;
		wr(`ASC_OFF_CTRL, 32'h0);
		wr(`ASC_OFF_CTRL, 32'h5);
		// Free running would be on the second step by now
		repeat (40) @(posedge hclk);
		@(negedge hclk);
		cmp("held step", 5, seq_num);
		@(posedge hclk);
		event_in <= 1'b1;
		repeat (30) @(posedge hclk);
		event_in <= 1'b0;
		repeat (5) @(posedge hclk);
		@(negedge hclk);
		// A long event level must advance only once
		cmp("next step", 6, seq_num);
		@(posedge hclk);
	endtask
	task t_jump;
		wr(`ASC_OFF_CTRL, 32'h0);
		wr(`ASC_OFF_TADDR, 32'h1);
		wr(`ASC_OFF_TLO, 32'h2);
		wr(`ASC_OFF_THI, 32'h40600000);
		wr(`ASC_OFF_CTRL, 32'h1);
		// Auto mode must still dwell on the flagged second step
		repeat (60) @(posedge hclk);
		@(negedge hclk);
		cmp("jump hold", 6, seq_num);
		@(posedge hclk);
		event_in <= 1'b1;
		repeat (6) @(posedge hclk);
		@(negedge hclk);
		cmp("jump advance", 7, seq_num);
		@(posedge hclk);
		event_in <= 1'b0;
	endtask
	task end_of_test;
		$display("errors %0d checks %0d", err_total, check_count);
		if (err_total == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		hresetn = 1'b0;
		event_in = 1'b0;
		err_total = 0;
		check_count = 0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_regs;
		t_block;
		t_once;
		t_step;
		t_jump;
		end_of_test;
	end
	initial begin
		for (cyc = 0; cyc < 20000; cyc = cyc + 1) @(posedge hclk);
		err_total = err_total + 1;
		end_of_test;
	end
endmodule
